// ===== design/cgcr_regs.sv
// Global chip configuration register bank behind the host index/data ports
`timescale 1ns/10ps
`default_nettype none

// Function
// [RULE1] Global registers occupy indexes 0x00 to 0x2F.
// [RULE2] All eight index bits select the register.
// [RULE3] Unimplemented indexes and bits ignore writes and read zero.
// [RULE4] Host writes index port, then accesses that register via data port.
// [RULE5] Configuration access honoured only in configuration mode.
// [RULE6] Writing one to bit 0 of index 0x02 triggers soft reset.
// [RULE7] Soft reset bit clears itself after the write.
// [RULE8] Index 0x03 bit 7 enables run-mode watchdog and interrupt register access.
// [RULE9] Index 0x03 bits 1:0 pick run-mode index port EA, E4, E2, E0.
// [RULE10] Index 0x07 selects the logical unit reached through the data port.
// [RULE11] Activate acts only on the currently selected unit.
// [RULE12] Index 0x20 is a read-only identity code, ignoring writes.
// [RULE13] Index 0x21 is a read-only revision code.
// [RULE14] Index 0x22 holds unit power enables on bits 0, 3, 4, 5.
// [RULE15] Index 0x23 holds unit power-management enables on the same bits.
// [RULE16] Power-on or reset-drive returns the global registers to defaults.
// [RULE17] Outside configuration mode data-port writes ignored, reads return zero.
module cgcr_regs
    import cgcr_pkg::*;
#(
    parameter logic [15:0] CFG_BASE = 16'h03F0, // Config index port address
    parameter logic [7:0]  CHIP_ID  = 8'h5A,    // Arbitrary identity value
    parameter logic [7:0]  CHIP_REV = 8'h02     // Arbitrary revision value
)
(
    input  wire logic              sys_clk,        // 20 MHz clock
    input  wire logic              srst,           // Power-on reset, sync
    input  wire logic              resetDrive,     // Host reset-drive
    input  wire logic              cfgMode,        // Configuration mode active
    input  wire cgcr_bus_type      hostBus,        // Host access strobes
    output logic [7:0]             rdData,         // Read answer
    output logic                   rdValid,        // Read answer valid
    output cgcr_unit_req_type      unitReq,        // Per-unit register access
    input  wire logic [7:0]        unitRdData,     // Per-unit read data
    output cgcr_cfg_type           cfgState,       // Global settings
    output logic                   softResetPulse  // Soft reset to units
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (CFG_BASE[0] != 1'b0)
    begin : gBadCfgBase
        $error("CFG_BASE must be even");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic isGlobal(input logic [7:0] idx);
        isGlobal = (idx <= IDX_GLOBAL_HI);
    endfunction : isGlobal

    function automatic logic runReachable(input logic [7:0] idx);
        runReachable = ((idx >= MGMT_IDX_LO) && (idx <= MGMT_IDX_HI))
                       || (idx == WDOG_CTRL_IDX);
    endfunction : runReachable

    function automatic logic [7:0] runPortOf(input logic [1:0] sel);
        unique case (sel)
            2'b11: runPortOf = RUN_PORT_11;
            2'b10: runPortOf = RUN_PORT_10;
            2'b01: runPortOf = RUN_PORT_01;
            2'b00: runPortOf = RUN_PORT_00;
        endcase
    endfunction : runPortOf

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]        cfgIdx_q;
    logic [7:0]        runIdx_q;
    logic [7:0]        runCtl_q;
    logic [7:0]        unitSel_q;
    logic [7:0]        pwrEn_q;
    logic [7:0]        pwrMgmt_q;
    logic              softRst_q;
    cgcr_unit_req_type unitReq_q;
    cgcr_unit_req_type unitReq_d;
    logic              rdPend_q;
    logic              rdUnit_q;
    logic [7:0]        rdLocal_q;
    logic [7:0]        rdLocal_d;
    logic              rdUnit_d;
    logic [7:0]        rdData_q;
    logic              rdValid_q;
    logic              hitCfgIdx;
    logic              hitCfgData;
    logic              hitRunIdx;
    logic              hitRunData;
    logic              globRst;
    logic              cfgWrIdx;
    logic              cfgWrData;
    logic              cfgRdData;
    logic              runWrIdx;
    logic              runOk;
    logic              anyRead;
    logic [7:0]        globRd;

    // ------------------------------------------------------------
    // Port decode
    // ------------------------------------------------------------
    cgcr_port_decode u_decode
    (
        .addr       (hostBus.addr),
        .cfgBase    (CFG_BASE),
        .runBase    (runPortOf(runCtl_q[1:0])),
        .hitCfgIdx  (hitCfgIdx),
        .hitCfgData (hitCfgData),
        .hitRunIdx  (hitRunIdx),
        .hitRunData (hitRunData)
    );

    // ------------------------------------------------------------
    // Access qualification
    // ------------------------------------------------------------
    always_comb
    begin
        globRst   = srst | resetDrive;                            // [RULE16]
        cfgWrIdx  = hostBus.write & hitCfgIdx & cfgMode;          // [RULE5]
        cfgWrData = hostBus.write & hitCfgData & cfgMode;         // [RULE5] [RULE17]
        cfgRdData = hostBus.read & hitCfgData & cfgMode;          // [RULE5] [RULE17]
        runWrIdx  = hostBus.write & hitRunIdx & ~cfgMode;
        runOk     = ~cfgMode & hitRunData & runCtl_q[RUN_ACC_BIT]
                    & runReachable(runIdx_q);                     // [RULE8]
        anyRead   = hostBus.read & (hitCfgIdx | hitCfgData
                    | (~cfgMode & (hitRunIdx | hitRunData)));
    end

    // ------------------------------------------------------------
    // Index registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (globRst)
        begin
            cfgIdx_q <= 8'h00;
        end
        else if (cfgWrIdx)
        begin
            cfgIdx_q <= hostBus.wdata;                            // [RULE2] [RULE4]
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (globRst)
        begin
            runIdx_q <= 8'h00;
        end
        else if (runWrIdx)
        begin
            runIdx_q <= hostBus.wdata;
        end
    end

    // ------------------------------------------------------------
    // Soft reset trigger
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (globRst)
        begin
            softRst_q <= 1'b0;
        end
        else
        begin
            softRst_q <= cfgWrData && (cfgIdx_q == IDX_SOFT_RST)
                         && hostBus.wdata[SOFT_RST_BIT];          // [RULE6] [RULE7]
        end
    end

    // ------------------------------------------------------------
    // Run-mode port control
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (globRst)
        begin
            runCtl_q <= RST_RUN_IDX;                              // [RULE16]
        end
        else if (cfgWrData && (cfgIdx_q == IDX_RUN_IDX))
        begin
            runCtl_q <= hostBus.wdata & RUN_IDX_MASK;             // [RULE8] [RULE9] [RULE3]
        end
    end

    // ------------------------------------------------------------
    // Unit selector
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (globRst)
        begin
            unitSel_q <= RST_UNIT_SEL;                            // [RULE16]
        end
        else if (cfgWrData && (cfgIdx_q == IDX_UNIT_SEL))
        begin
            unitSel_q <= hostBus.wdata;                           // [RULE10]
        end
    end

    // ------------------------------------------------------------
    // Power enables and management
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (globRst)
        begin
            pwrEn_q <= RST_PWR_EN;                                // [RULE16]
        end
        else if (cfgWrData && (cfgIdx_q == IDX_PWR_EN))
        begin
            pwrEn_q <= hostBus.wdata & UNIT_PWR_MASK;             // [RULE14] [RULE3]
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (globRst)
        begin
            pwrMgmt_q <= RST_PWR_MGMT;                            // [RULE16]
        end
        else if (cfgWrData && (cfgIdx_q == IDX_PWR_MGMT))
        begin
            pwrMgmt_q <= hostBus.wdata & UNIT_PWR_MASK;           // [RULE15] [RULE3]
        end
    end

    // ------------------------------------------------------------
    // Per-unit access routing
    // ------------------------------------------------------------
    always_comb
    begin
        unitReq_d          = '0;
        unitReq_d.unit     = unitSel_q;                           // [RULE10]
        unitReq_d.index    = cfgIdx_q;
        unitReq_d.data     = hostBus.wdata;
        if (hitCfgData && cfgMode && !isGlobal(cfgIdx_q))
        begin
            unitReq_d.wr       = hostBus.write;                   // [RULE4]
            unitReq_d.rd       = hostBus.read;
            unitReq_d.activate = hostBus.write
                                 && (cfgIdx_q == IDX_ACTIVATE);   // [RULE11]
        end
        else if (runOk)
        begin
            unitReq_d.unit  = AUX_UNIT;                           // [RULE8]
            unitReq_d.index = runIdx_q;
            unitReq_d.wr    = hostBus.write;
            unitReq_d.rd    = hostBus.read;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (globRst)
        begin
            unitReq_q <= '0;
        end
        else
        begin
            unitReq_q <= unitReq_d;
        end
    end

    // ------------------------------------------------------------
    // Global read mux
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (cfgIdx_q)                                    // [RULE1] [RULE2]
            IDX_RUN_IDX:  globRd = runCtl_q;                      // [RULE9]
            IDX_UNIT_SEL: globRd = unitSel_q;
            IDX_CHIP_ID:  globRd = CHIP_ID;                       // [RULE12]
            IDX_CHIP_REV: globRd = CHIP_REV;                      // [RULE13]
            IDX_PWR_EN:   globRd = pwrEn_q;
            IDX_PWR_MGMT: globRd = pwrMgmt_q;
            default:      globRd = 8'h00;                         // [RULE3] [RULE7]
        endcase
    end

    always_comb
    begin
        rdLocal_d = 8'h00;                                        // [RULE17]
        rdUnit_d  = 1'b0;
        if (cfgMode && hitCfgIdx)
        begin
            rdLocal_d = cfgIdx_q;
        end
        else if (cfgRdData && isGlobal(cfgIdx_q))
        begin
            rdLocal_d = globRd;
        end
        else if (cfgRdData || (runOk && hostBus.read))
        begin
            rdUnit_d = 1'b1;
        end
        else if (!cfgMode && hitRunIdx)
        begin
            rdLocal_d = runIdx_q;
        end
    end

    // ------------------------------------------------------------
    // Read pipeline
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (globRst)
        begin
            rdPend_q  <= 1'b0;
            rdUnit_q  <= 1'b0;
            rdLocal_q <= 8'h00;
        end
        else
        begin
            rdPend_q  <= anyRead;
            rdUnit_q  <= anyRead & rdUnit_d;
            rdLocal_q <= rdLocal_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (globRst)
        begin
            rdData_q  <= 8'h00;
            rdValid_q <= 1'b0;
        end
        else
        begin
            rdData_q  <= rdUnit_q ? unitRdData : rdLocal_q;
            rdValid_q <= rdPend_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb
    begin
        rdData               = rdData_q;
        rdValid              = rdValid_q;
        unitReq              = unitReq_q;
        softResetPulse       = softRst_q;
        cfgState.runAccessEn = runCtl_q[RUN_ACC_BIT];             // [RULE8]
        cfgState.runPortAddr = runPortOf(runCtl_q[1:0]);          // [RULE9]
        cfgState.unitSel     = unitSel_q;
        cfgState.powerOn     = pwrEn_q;                           // [RULE14]
        cfgState.powerMgmt   = pwrMgmt_q;                         // [RULE15]
    end

endmodule : cgcr_regs

`default_nettype wire

// ===== shared/cgcr_pkg.sv
// Package: constants and carrier types of the global configuration register bank
package cgcr_pkg;

    // ------------------------------------------------------------
    // Register indexes
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_SOFT_RST  = 8'h02;
    localparam logic [7:0] IDX_RUN_IDX   = 8'h03;
    localparam logic [7:0] IDX_UNIT_SEL  = 8'h07;
    localparam logic [7:0] IDX_CHIP_ID   = 8'h20;
    localparam logic [7:0] IDX_CHIP_REV  = 8'h21;
    localparam logic [7:0] IDX_PWR_EN    = 8'h22;
    localparam logic [7:0] IDX_PWR_MGMT  = 8'h23;
    localparam logic [7:0] IDX_GLOBAL_HI = 8'h2F;
    localparam logic [7:0] IDX_ACTIVATE  = 8'h30;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int         SOFT_RST_BIT  = 0;
    localparam int         RUN_ACC_BIT   = 7;
    localparam logic [7:0] RUN_IDX_MASK  = 8'h83;
    localparam logic [7:0] UNIT_PWR_MASK = 8'h39;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_RUN_IDX   = 8'h03;
    localparam logic [7:0] RST_UNIT_SEL  = 8'h00;
    localparam logic [7:0] RST_PWR_EN    = 8'h00;
    localparam logic [7:0] RST_PWR_MGMT  = 8'h00;

    // ------------------------------------------------------------
    // Run-mode port addresses and reachable registers
    // ------------------------------------------------------------
    localparam logic [7:0] RUN_PORT_00   = 8'hE0;
    localparam logic [7:0] RUN_PORT_01   = 8'hE2;
    localparam logic [7:0] RUN_PORT_10   = 8'hE4;
    localparam logic [7:0] RUN_PORT_11   = 8'hEA;
    localparam logic [7:0] AUX_UNIT      = 8'h08;
    localparam logic [7:0] MGMT_IDX_LO   = 8'hB4;
    localparam logic [7:0] MGMT_IDX_HI   = 8'hB7;
    localparam logic [7:0] WDOG_CTRL_IDX = 8'hF4;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        write;
        logic        read;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cgcr_bus_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       activate;
        logic [7:0] unit;
        logic [7:0] index;
        logic [7:0] data;
    } cgcr_unit_req_type;

    typedef struct packed {
        logic       runAccessEn;
        logic [7:0] runPortAddr;
        logic [7:0] unitSel;
        logic [7:0] powerOn;
        logic [7:0] powerMgmt;
    } cgcr_cfg_type;

endpackage : cgcr_pkg

// ===== design/cgcr_port_decode.sv
// Host address decode for the configuration and run-mode index/data ports
`timescale 1ns/10ps
`default_nettype none

module cgcr_port_decode
    import cgcr_pkg::*;
(
    input  wire logic [15:0] addr,        // Host I/O address
    input  wire logic [15:0] cfgBase,     // Configuration index port address
    input  wire logic [7:0]  runBase,     // Run-mode index port address
    output logic             hitCfgIdx,   // Config index port
    output logic             hitCfgData,  // Config data port
    output logic             hitRunIdx,   // Run-mode index port
    output logic             hitRunData   // Run-mode data port
);

    // ------------------------------------------------------------
    // Port match
    // ------------------------------------------------------------
    logic [15:0] cfgDataAddr;
    logic [15:0] runIdxAddr;
    logic [15:0] runDataAddr;

    always_comb
    begin
        cfgDataAddr = cfgBase + 16'h0001;
        runIdxAddr  = {8'h00, runBase};
        runDataAddr = runIdxAddr + 16'h0001;
        hitCfgIdx   = (addr == cfgBase);
        hitCfgData  = (addr == cfgDataAddr);
        hitRunIdx   = (addr == runIdxAddr);
        hitRunData  = (addr == runDataAddr);
    end

endmodule : cgcr_port_decode

`default_nettype wire

// ===== test/cgcr_host_bfm.sv
// Host bus master model for index/data port cycles
`timescale 1ns/10ps
`default_nettype none

module cgcr_host_bfm
    import cgcr_pkg::*;
(
    input  wire logic       sys_clk, // Clock
    output var cgcr_bus_type hostBus, // Host strobes
    input  wire logic [7:0] rdData,  // Read answer
    input  wire logic       rdValid  // Read answer valid
);
    initial hostBus = '0;

    // Released address and data show the inverse, never the old value
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        hostBus = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        hostBus = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(negedge sys_clk);
        hostBus = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        hostBus = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: 8'hFF};
        @(posedge sys_clk);
        #1;
        v = rdValid;
        d = rdData;
    endtask : rd
endmodule : cgcr_host_bfm

`default_nettype wire

// ===== test/cgcr_regs_sva.sv
// Concurrent checks on the register bank ports
`timescale 1ns/10ps
`default_nettype none

module cgcr_regs_sva
    import cgcr_pkg::*;
#(
    parameter logic [15:0] CFG_BASE = 16'h03F0 // Config index port
)
(
    input wire logic              sys_clk,        // Clock
    input wire logic              srst,           // Reset
    input wire logic              resetDrive,     // Host reset-drive
    input wire logic              cfgMode,        // Config mode
    input wire cgcr_bus_type      hostBus,        // Host strobes
    input wire logic [7:0]        rdData,         // Read answer
    input wire logic              rdValid,        // Read valid
    input wire cgcr_unit_req_type unitReq,        // Unit access
    input wire logic [7:0]        unitRdData,     // Unit read data
    input wire cgcr_cfg_type      cfgState,       // Global settings
    input wire logic              softResetPulse  // Soft reset pulse
);
    localparam logic [7:0] PORT_TAB [4] = '{RUN_PORT_00, RUN_PORT_01, RUN_PORT_10, RUN_PORT_11};
    logic       rst;
    logic       dataWr;
    logic       softHit;
    logic [7:0] idx_q;

    assign rst     = srst || resetDrive;
    assign dataWr  = hostBus.write && cfgMode && hostBus.addr == CFG_BASE + 16'h0001;
    assign softHit = dataWr && idx_q == IDX_SOFT_RST && hostBus.wdata[SOFT_RST_BIT];

    // Shadow of the config index register
    always_ff @(posedge sys_clk)
        if (rst)
            idx_q <= 8'h00;
        else if (hostBus.write && cfgMode && hostBus.addr == CFG_BASE)
            idx_q <= hostBus.wdata;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    rd_latency_a: assert property (hostBus.read && hostBus.addr[15:1] == CFG_BASE[15:1]
        |-> ##2 rdValid)
        else $error("config read not answered");
    valid_cause_a: assert property (rdValid |-> $past(hostBus.read, 2))
        else $error("read answer without a read");
    unit_read_a: assert property (unitReq.rd |=> rdValid && rdData == $past(unitRdData))
        else $error("unit read data not returned");
    soft_pulse_a: assert property (softHit |=> softResetPulse ##1 !softResetPulse)
        else $error("soft reset pulse wrong");
    soft_cause_a: assert property (softResetPulse |-> $past(softHit))
        else $error("soft reset pulse without trigger");
    power_wr_a: assert property (dataWr && idx_q == IDX_PWR_EN |=>
        cfgState.powerOn == ($past(hostBus.wdata) & UNIT_PWR_MASK))
        else $error("power enable write wrong");
    mgmt_wr_a: assert property (dataWr && idx_q == IDX_PWR_MGMT |=>
        cfgState.powerMgmt == ($past(hostBus.wdata) & UNIT_PWR_MASK))
        else $error("power management write wrong");
    run_cfg_a: assert property (dataWr && idx_q == IDX_RUN_IDX |=>
        cfgState.runPortAddr == PORT_TAB[$past(hostBus.wdata[1:0])]
        && cfgState.runAccessEn == $past(hostBus.wdata[RUN_ACC_BIT]))
        else $error("run index setting wrong");
    unit_sel_a: assert property (dataWr && idx_q == IDX_UNIT_SEL |=>
        cfgState.unitSel == $past(hostBus.wdata))
        else $error("unit selector write wrong");
    activate_a: assert property (dataWr && idx_q == IDX_ACTIVATE |=>
        unitReq.wr && unitReq.activate && unitReq.unit == cfgState.unitSel)
        else $error("activate not sent to unit");
    outside_cfg_a: assert property (hostBus.write && !cfgMode
        && hostBus.addr[15:1] == CFG_BASE[15:1] |=> $stable(cfgState))
        else $error("config write honoured outside mode");
    reset_val_a: assert property (disable iff (1'b0) rst |=>
        cfgState.runPortAddr == RUN_PORT_11 && !cfgState.runAccessEn
        && cfgState.unitSel == RST_UNIT_SEL && cfgState.powerOn == RST_PWR_EN
        && cfgState.powerMgmt == RST_PWR_MGMT)
        else $error("defaults not restored by reset");
endmodule : cgcr_regs_sva

bind cgcr_regs cgcr_regs_sva #(.CFG_BASE(CFG_BASE)) cgcr_regs_sva_inst (
    .sys_clk(sys_clk), .srst(srst), .resetDrive(resetDrive), .cfgMode(cfgMode),
    .hostBus(hostBus), .rdData(rdData), .rdValid(rdValid), .unitReq(unitReq),
    .unitRdData(unitRdData), .cfgState(cfgState), .softResetPulse(softResetPulse));

`default_nettype wire

// ===== test/tb_chip_global_config_regs.sv
// Self-checking bench for the global configuration register bank
`timescale 1ns/10ps
`default_nettype none

module tb_chip_global_config_regs
    import cgcr_pkg::*;
;
    localparam logic [15:0] CFG = 16'h03F0;
    localparam logic [7:0]  ID  = 8'h6B; // Arbitrary identity value
    localparam logic [7:0]  REV = 8'h07; // Arbitrary revision value

    logic              sys_clk;
    logic              srst;
    logic              resetDrive;
    logic              cfgMode;
    cgcr_bus_type      hostBus;
    logic [7:0]        rdData;
    logic              rdValid;
    cgcr_unit_req_type unitReq;
    logic [7:0]        unitRdData;
    logic [7:0]        pat;
    cgcr_cfg_type      cfgState;
    logic              softResetPulse;
    int                errTotal;
    int                nTests;

    cgcr_regs #(.CFG_BASE(CFG), .CHIP_ID(ID), .CHIP_REV(REV)) cgcr_regs_inst (
        .sys_clk(sys_clk), .srst(srst), .resetDrive(resetDrive), .cfgMode(cfgMode),
        .hostBus(hostBus), .rdData(rdData), .rdValid(rdValid), .unitReq(unitReq),
        .unitRdData(unitRdData), .cfgState(cfgState), .softResetPulse(softResetPulse));

    cgcr_host_bfm cgcr_host_bfm_inst (.sys_clk(sys_clk), .hostBus(hostBus),
        .rdData(rdData), .rdValid(rdValid));

    // Logical unit stand-in: answers index xor unit, else a moving pattern
    always @(negedge sys_clk)
        pat <= srst ? 8'h00 : pat + 8'h01;
    assign unitRdData = unitReq.rd ? (unitReq.index ^ unitReq.unit) : pat;

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        if (errTotal == 0 && nTests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic hw(input logic [15:0] a, input logic [7:0] d);
        cgcr_host_bfm_inst.wr(a, d);
    endtask : hw

    task automatic cw(input logic [7:0] idx, input logic [7:0] d);
        hw(CFG, idx);
        hw(CFG + 16'h0001, d);
    endtask : cw

    task automatic cr(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        hw(CFG, idx);
        cgcr_host_bfm_inst.rd(CFG + 16'h0001, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask : cr

    task automatic t_defaults();
        cr(IDX_RUN_IDX, 8'h03);
        cr(IDX_UNIT_SEL, 8'h00);
        cr(IDX_PWR_EN, 8'h00);
        cr(IDX_PWR_MGMT, 8'h00);
        chk(cfgState.runPortAddr, 8'hEA);
    endtask : t_defaults

    task automatic t_ident_reserved();
        logic [7:0] rsv [7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h08, 8'h1F};
        cw(IDX_CHIP_ID, ~ID);
        cw(IDX_CHIP_REV, ~REV);
        cr(IDX_CHIP_ID, ID);
        cr(IDX_CHIP_REV, REV);
        foreach (rsv[i])
        begin
            cw(rsv[i], 8'hFE);
            cr(rsv[i], 8'h00);
        end
    endtask : t_ident_reserved

    task automatic t_power();
        cw(IDX_PWR_EN, 8'hFF);
        chk(cfgState.powerOn, 8'h39);
        cr(IDX_PWR_EN, 8'h39);
        cw(IDX_PWR_MGMT, 8'hF6);
        chk(cfgState.powerMgmt, 8'h30);
        cr(IDX_PWR_MGMT, 8'h30);
        cw(IDX_PWR_EN, 8'h09);
        chk(cfgState.powerOn, 8'h09);
    endtask : t_power

    task automatic t_run_index();
        logic [7:0] tab [4] = '{8'hE0, 8'hE2, 8'hE4, 8'hEA};
        for (int i = 0; i < 4; i++)
        begin
            cw(IDX_RUN_IDX, {6'h3F, i[1:0]});
            chk(cfgState.runPortAddr, tab[i]);
            chk({7'h00, cfgState.runAccessEn}, 8'h01);
            cr(IDX_RUN_IDX, {6'h20, i[1:0]});
        end
    endtask : t_run_index

    task automatic t_soft_reset();
        cw(IDX_SOFT_RST, 8'hFE);
        chk({7'h00, softResetPulse}, 8'h00);
        cw(IDX_SOFT_RST, 8'h01);
        chk({7'h00, softResetPulse}, 8'h01);
        @(negedge sys_clk);
        chk({7'h00, softResetPulse}, 8'h00);
        cr(IDX_SOFT_RST, 8'h00);
    endtask : t_soft_reset

    task automatic t_units();
        cw(IDX_UNIT_SEL, 8'h05);
        chk(cfgState.unitSel, 8'h05);
        cw(IDX_ACTIVATE, 8'h01);
        chk({unitReq.wr, unitReq.activate, 6'h00}, 8'hC0);
        chk(unitReq.unit, 8'h05);
        cr(8'h60, 8'h65);
        cw(8'hA2, 8'hFF);
        chk(unitReq.index, 8'hA2);
        chk(unitReq.data, 8'hFF);
        chk(cfgState.powerOn, 8'h09);
    endtask : t_units

    task automatic t_outside();
        logic [7:0] d;
        logic       v;
        cfgMode = 1'b0;
        hw(CFG, IDX_PWR_MGMT);
        hw(CFG + 16'h0001, 8'hFF);
        chk(cfgState.powerOn, 8'h09);
        chk(cfgState.powerMgmt, 8'h30);
        cgcr_host_bfm_inst.rd(CFG + 16'h0001, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, 8'h00);
        hw(16'h00EA, WDOG_CTRL_IDX);
        hw(16'h00EB, 8'h77);
        chk({unitReq.wr, 7'h00}, 8'h80);
        chk(unitReq.unit, AUX_UNIT);
        chk(unitReq.index, WDOG_CTRL_IDX);
        cfgMode = 1'b1;
        cw(IDX_RUN_IDX, 8'h03);
        cfgMode = 1'b0;
        hw(16'h00EA, WDOG_CTRL_IDX);
        hw(16'h00EB, 8'h77);
        chk({unitReq.wr, 7'h00}, 8'h00);
        cfgMode = 1'b1;
    endtask : t_outside

    task automatic t_reset_drive();
        cw(IDX_RUN_IDX, 8'h80);
        cw(IDX_UNIT_SEL, 8'h03);
        resetDrive = 1'b1;
        @(negedge sys_clk);
        resetDrive = 1'b0;
        chk(cfgState.powerOn, 8'h00);
        chk(cfgState.runPortAddr, 8'hEA);
        cr(IDX_RUN_IDX, 8'h03);
        cr(IDX_UNIT_SEL, 8'h00);
        cr(IDX_PWR_MGMT, 8'h00);
    endtask : t_reset_drive

    initial
    begin
        srst = 1'b1;
        resetDrive = 1'b0;
        cfgMode = 1'b1;
        errTotal = 0;
        nTests = 0;
        repeat (20) @(negedge sys_clk);
        srst = 1'b0;
        t_defaults();
        t_ident_reserved();
        t_power();
        t_run_index();
        t_soft_reset();
        t_units();
        t_outside();
        t_reset_drive();
        tally_and_finish();
    end

    initial
    begin
        repeat (4000) @(posedge sys_clk);
        errTotal++;
        tally_and_finish();
    end
endmodule : tb_chip_global_config_regs

`default_nettype wire
